// ---- hw/arc_fault_map.svh ----
/*
 * Constants for the arc fault zone trip block: counts, widths, resets,
 * default time base. Assumes inclusion from design files only.
 */
`ifndef ARC_FAULT_MAP_SVH
`define ARC_FAULT_MAP_SVH

`define ARC_CHANNELS 4
`define ARC_ZONES 4
`define ARC_MAX_SENSORS 3
`define ARC_COUNT_W 2
`define ARC_SAMPLE_W 16
`define ARC_CLK_MHZ 125
`define ARC_TIME_BASE_US 5000
`define ARC_BASE_CYCLES (`ARC_TIME_BASE_US * `ARC_CLK_MHZ)
`define ARC_SAMPLES_PER_BASE 8
`define ARC_ZERO_COUNT 2'h0
`define ARC_ZERO_ZONES 4'h0
`define ARC_PULSE_MAX_CYCLES 125

`endif

// ---- hw/arc_fault_pkg.sv ----
/*
 * Types for the arc fault zone trip block.
 * Assumes the map header supplies every number.
 */
`include "arc_fault_map.svh"

package arc_fault_pkg;

    // Current supervision selection
    typedef enum logic [1:0]
    {
        CUR_NONE = 2'b00,
        CUR_PHASE = 2'b01,
        CUR_RESIDUAL = 2'b10,
        CUR_BOTH = 2'b11
    } cur_sel_t;

    // Residual channel selection
    typedef enum logic [1:0]
    {
        RES_NONE = 2'b00,
        RES_ONE = 2'b01,
        RES_TWO = 2'b10
    } res_sel_t;

endpackage

// ---- hw/arc_fault_zone_trip.sv ----
/*
 * Arc fault zone trip logic: light and pressure per channel, arc binary
 * input, phase and residual current conditions, per-zone trip/blocked.
 * Assumes all inputs synchronous to sys_clk and settings held static.
 */
`timescale 1ns/1ns
`include "arc_fault_map.svh"

module arc_fault_zone_trip #(
    parameter int CHANNELS = `ARC_CHANNELS,
    parameter int ZONES = `ARC_ZONES,
    parameter int SAMPLE_W = `ARC_SAMPLE_W,
    parameter int BASE_CYCLES = `ARC_BASE_CYCLES,
    parameter int PULSE_CYCLES = `ARC_PULSE_MAX_CYCLES
)
(
    input wire logic sys_clk,
    input wire logic nrst,
    // Sensor side
    input wire logic [CHANNELS-1:0] light_in,
    input wire logic [CHANNELS-1:0] pressure_in,
    input wire logic [CHANNELS*`ARC_COUNT_W-1:0] detected_sensors,
    input wire logic [CHANNELS*`ARC_COUNT_W-1:0] configured_sensors,
    input wire logic [3:0] connected_units,
    input wire logic [3:0] configured_units,
    input wire logic arc_binary_input,
    input wire logic test_pulse_filter_enable,
    // Current samples
    input wire logic [SAMPLE_W-1:0] phase_a_samples,
    input wire logic [SAMPLE_W-1:0] phase_b_samples,
    input wire logic [SAMPLE_W-1:0] phase_c_samples,
    input wire logic [SAMPLE_W-1:0] residual_samples_one,
    input wire logic [SAMPLE_W-1:0] residual_samples_two,
    input wire logic sample_valid,
    input wire logic [SAMPLE_W-1:0] phase_pickup,
    input wire logic [SAMPLE_W-1:0] residual_pickup,
    input wire logic [7:0] required_samples,
    input wire arc_fault_pkg::cur_sel_t current_mode,
    input wire arc_fault_pkg::res_sel_t residual_select,
    input wire logic phase_block,
    input wire logic residual_block,
    input wire logic zone_block,
    // Zone settings
    input wire logic [ZONES-1:0] zone_enable,
    input wire logic [ZONES*CHANNELS-1:0] zone_light_map,
    input wire logic [ZONES-1:0] zone_phase_enable,
    input wire logic [ZONES-1:0] zone_residual_enable,
    input wire logic [1:0] fast_one_select,
    input wire logic [1:0] fast_two_select,
    // Outputs
    output logic [CHANNELS-1:0] light_detected,
    output logic arc_input_status,
    output logic phase_start,
    output logic residual_start,
    output logic phase_blocked,
    output logic residual_blocked,
    output logic [ZONES-1:0] zone_trip,
    output logic [ZONES-1:0] zone_blocked,
    output logic [CHANNELS-1:0] sensor_fault,
    output logic io_unit_fault,
    output logic fast_output_one,
    output logic fast_output_two
);

    // ******************************
    // Current conditions
    // ******************************
    logic phase_over;
    logic residual_over;
    logic phase_used;
    logic residual_used;
    logic [1:0] res_stream_en;

    // Supervision selection gates which comparators may ever start
    assign phase_used = current_mode[0];
    assign residual_used = current_mode[1];
    assign res_stream_en = {residual_select == arc_fault_pkg::RES_TWO,
                            residual_select == arc_fault_pkg::RES_ONE};

    over_limit_counter #(
        .WIDTH(SAMPLE_W),
        .STREAMS(3),
        .BASE_CYCLES(BASE_CYCLES)
    ) phase_counter (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .samples({phase_c_samples, phase_b_samples, phase_a_samples}),
        .stream_enable({3{phase_used}}),
        .sample_valid(sample_valid),
        .pickup_limit(phase_pickup),
        .required_count(required_samples),
        .over(phase_over)
    );

    over_limit_counter #(
        .WIDTH(SAMPLE_W),
        .STREAMS(2),
        .BASE_CYCLES(BASE_CYCLES)
    ) residual_counter (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .samples({residual_samples_two, residual_samples_one}),
        .stream_enable(res_stream_en & {2{residual_used}}),
        .sample_valid(sample_valid),
        .pickup_limit(residual_pickup),
        .required_count(required_samples),
        .over(residual_over)
    );

    // ******************************
    // Arc binary input
    // ******************************
    logic arc_bi_clean;

    pulse_reject_filter #(
        .MAX_PULSE(PULSE_CYCLES)
    ) bi_filter (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .raw_in(arc_binary_input),
        .filter_enable(test_pulse_filter_enable),
        .filtered(arc_bi_clean)
    );

    // ******************************
    // Combinational decisions
    // ******************************
    logic [CHANNELS-1:0] chan_sense;
    logic [CHANNELS-1:0] next_light_detected;
    logic [CHANNELS-1:0] next_sensor_fault;
    logic [ZONES-1:0] zone_met;
    logic [ZONES-1:0] next_zone_trip;
    logic [ZONES-1:0] next_zone_blocked;
    logic phase_cond;
    logic residual_cond;

    // Pressure sensors share the light path of their channel
    assign chan_sense = light_in | pressure_in;
    assign phase_cond = phase_over && phase_used;
    assign residual_cond = residual_over && residual_used;

    genvar c;
    generate
        for (c = 0; c < CHANNELS; c++)
        begin : chan
            // Count field 0..3 covers none to three sensors
            assign next_light_detected[c] = chan_sense[c];
            assign next_sensor_fault[c] =
                detected_sensors[c*`ARC_COUNT_W +: `ARC_COUNT_W] !=
                configured_sensors[c*`ARC_COUNT_W +: `ARC_COUNT_W];
        end
    endgenerate

    genvar z;
    generate
        for (z = 0; z < ZONES; z++)
        begin : zone
            logic light_ok;
            logic cur_ok;
            // Any assigned channel sensing light satisfies the light term
            assign light_ok = |(chan_sense & zone_light_map[z*CHANNELS +: CHANNELS]);
            // Each enabled current term must also hold
            assign cur_ok = (!zone_phase_enable[z] || phase_cond) &&
                            (!zone_residual_enable[z] || residual_cond);
            assign zone_met[z] = zone_enable[z] && light_ok && cur_ok;
            // Blocking wins, so the two outputs are exclusive
            assign next_zone_trip[z] = zone_met[z] && !zone_block;
            assign next_zone_blocked[z] = zone_met[z] && zone_block;
        end
    endgenerate

    // Fast output source: 0 none, 1 phase start, 2 residual start, 3 master trip
    function automatic logic fast_pick(input logic [1:0] sel, input logic ps,
                                       input logic rs, input logic mt);
        logic r;
        r = 1'b0;
        unique case (sel)
            2'b00: r = 1'b0;
            2'b01: r = ps;
            2'b10: r = rs;
            2'b11: r = mt;
        endcase
        return r;
    endfunction

    // ******************************
    // Next output values
    // ******************************
    logic next_arc_input_status;
    logic next_phase_start;
    logic next_residual_start;
    logic next_phase_blocked;
    logic next_residual_blocked;
    logic next_io_unit_fault;
    logic next_fast_one;
    logic next_fast_two;

    always_comb
    begin
        next_arc_input_status = arc_bi_clean;
        next_phase_start = phase_cond && !phase_block;
        next_residual_start = residual_cond && !residual_block;
        next_phase_blocked = phase_cond && phase_block;
        next_residual_blocked = residual_cond && residual_block;
        next_io_unit_fault = connected_units != configured_units;
        next_fast_one = fast_pick(fast_one_select, next_phase_start,
                                  next_residual_start, |next_zone_trip);
        next_fast_two = fast_pick(fast_two_select, next_phase_start,
                                  next_residual_start, |next_zone_trip);
    end

    // ******************************
    // Output registers
    // ******************************
    // Registered outputs trade one cycle of latency for glitch-free pins
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            light_detected <= `ARC_ZERO_ZONES;
            arc_input_status <= 1'b0;
            phase_start <= 1'b0;
            residual_start <= 1'b0;
            phase_blocked <= 1'b0;
            residual_blocked <= 1'b0;
            zone_trip <= `ARC_ZERO_ZONES;
            zone_blocked <= `ARC_ZERO_ZONES;
            sensor_fault <= `ARC_ZERO_ZONES;
            io_unit_fault <= 1'b0;
            fast_output_one <= 1'b0;
            fast_output_two <= 1'b0;
        end
        else
        begin
            light_detected <= next_light_detected;
            arc_input_status <= next_arc_input_status;
            phase_start <= next_phase_start;
            residual_start <= next_residual_start;
            phase_blocked <= next_phase_blocked;
            residual_blocked <= next_residual_blocked;
            zone_trip <= next_zone_trip;
            zone_blocked <= next_zone_blocked;
            sensor_fault <= next_sensor_fault;
            io_unit_fault <= next_io_unit_fault;
            fast_output_one <= next_fast_one;
            fast_output_two <= next_fast_two;
        end
    end

    // Zone enables and sensor counts default to zero via external settings
    // (disabled, no sensors), which this block takes as static levels.

endmodule

// ---- hw/over_limit_counter.sv ----
/*
 * Counts samples above a limit over one time base window and reports a
 * condition when the count exceeds the required number.
 * Assumes sample_valid pulses once per new sample, synchronous to sys_clk.
 */
`timescale 1ns/1ns
`include "arc_fault_map.svh"

module over_limit_counter #(
    parameter int WIDTH = `ARC_SAMPLE_W,
    parameter int STREAMS = 3,
    parameter int BASE_CYCLES = `ARC_BASE_CYCLES
)
(
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic [STREAMS*WIDTH-1:0] samples,
    input wire logic [STREAMS-1:0] stream_enable,
    input wire logic sample_valid,
    input wire logic [WIDTH-1:0] pickup_limit,
    input wire logic [7:0] required_count,
    output logic over
);

    // ******************************
    // Per-stream comparison
    // ******************************
    logic [STREAMS-1:0] above;
    genvar g;
    generate
        for (g = 0; g < STREAMS; g++)
        begin : cmp
            assign above[g] = stream_enable[g] && (samples[g*WIDTH +: WIDTH] > pickup_limit);
        end
    endgenerate

    // ******************************
    // Window counter
    // ******************************
    logic [31:0] base_cnt;
    logic [31:0] next_base_cnt;
    logic [7:0] hits;
    logic [7:0] next_hits;
    logic next_over;

    // Over sets as soon as the count exceeds the limit mid-window, and is re-evaluated only at each window end of the 5 ms base
    always_comb
    begin
        next_base_cnt = base_cnt + 32'h0000_0001;
        next_hits = hits;
        next_over = over;
        if (sample_valid && (|above) && (hits != 8'hff))
        begin
            next_hits = hits + 8'h01;
        end
        // Count must exceed the limit, not merely reach it
        if (hits > required_count)
        begin
            next_over = 1'b1;
        end
        if (base_cnt >= 32'(BASE_CYCLES - 1))
        begin
            next_base_cnt = 32'h0000_0000;
            next_hits = 8'h00;
            next_over = (hits > required_count);
        end
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            base_cnt <= 32'h0000_0000;
            hits <= 8'h00;
            over <= 1'b0;
        end
        else
        begin
            base_cnt <= next_base_cnt;
            hits <= next_hits;
            over <= next_over;
        end
    end

endmodule

// ---- hw/pulse_reject_filter.sv ----
/*
 * Rejects short supervision test pulses on the arc binary input.
 * Assumes the input is synchronous to sys_clk; a level longer than
 * MAX_PULSE cycles is passed as a real arc signal.
 */
`timescale 1ns/1ns
`include "arc_fault_map.svh"

module pulse_reject_filter #(
    parameter int MAX_PULSE = `ARC_PULSE_MAX_CYCLES
)
(
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic raw_in,
    input wire logic filter_enable,
    output logic filtered
);

    // ******************************
    // Length qualification
    // ******************************
    logic [15:0] run;
    logic [15:0] next_run;
    logic next_filtered;

    // Trade-off: a genuine input is delayed by MAX_PULSE cycles when filtering
    always_comb
    begin
        next_run = run;
        next_filtered = raw_in;
        if (!raw_in)
        begin
            next_run = 16'h0000;
        end
        else if (run != 16'hffff)
        begin
            next_run = run + 16'h0001;
        end
        if (filter_enable)
        begin
            next_filtered = raw_in && (run >= 16'(MAX_PULSE));
        end
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            run <= 16'h0000;
            filtered <= 1'b0;
        end
        else
        begin
            run <= next_run;
            filtered <= next_filtered;
        end
    end

endmodule

// ---- verification/arc_trip_checker_asserts.sv ----
/* Checker for the arc fault zone trip block.
   Assumes four channels and four zones; sees only top-level ports. */
`timescale 1ns/1ns
module arc_trip_checker
(
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic [3:0] light_in,
    input wire logic [3:0] pressure_in,
    input wire logic [7:0] detected_sensors,
    input wire logic [7:0] configured_sensors,
    input wire logic [3:0] connected_units,
    input wire logic [3:0] configured_units,
    input wire logic [3:0] zone_enable,
    input wire logic [15:0] zone_light_map,
    input wire logic [3:0] zone_phase_enable,
    input wire logic [3:0] zone_residual_enable,
    input wire logic zone_block,
    input wire logic phase_block,
    input wire logic [3:0] light_detected,
    input wire logic [3:0] zone_trip,
    input wire logic [3:0] zone_blocked,
    input wire logic [3:0] sensor_fault,
    input wire logic io_unit_fault,
    input wire logic phase_start,
    input wire logic phase_blocked
);
// ********
// Helpers
// ********
logic [3:0] seen;
logic [3:0] fault_exp;
logic [3:0] pure_light;

// Expected faults and light-only zones; zone index reuses channel loop
always_comb
begin
    seen = light_in | pressure_in;
    for (int c = 0; c < 4; c++)
    begin
        fault_exp[c] = detected_sensors[2*c+:2] != configured_sensors[2*c+:2];
        pure_light[c] = zone_enable[c] & ~zone_phase_enable[c] & ~zone_residual_enable[c]
            & (|(zone_light_map[4*c+:4] & seen));
    end
end

// ********
// Properties
// ********
default clocking cb @(posedge sys_clk); endclocking
default disable iff (!nrst);

a_light_follow: assert property ($past(nrst) |-> light_detected == $past(seen))
    else $error("light detected does not follow sensors");
a_sensor_count: assert property ($past(nrst) |-> sensor_fault == $past(fault_exp))
    else $error("sensor fault does not match count mismatch");
a_unit_count: assert property ($past(nrst) |->
    io_unit_fault == $past(connected_units != configured_units))
    else $error("unit fault does not match unit mismatch");
a_never_both: assert property ((zone_trip & zone_blocked) == 4'h0)
    else $error("zone trip and blocked together");
a_disabled_quiet: assert property ($past(nrst) |->
    ((zone_trip | zone_blocked) & ~$past(zone_enable)) == 4'h0)
    else $error("disabled zone is active");
a_block_wins: assert property ($past(zone_block) |-> zone_trip == 4'h0)
    else $error("zone tripped while blocked");
a_light_trip: assert property ($past(nrst) |->
    ((zone_trip | zone_blocked) & $past(pure_light)) == $past(pure_light))
    else $error("light-only zone did not act");
a_start_clear: assert property (phase_start |-> !$past(phase_block))
    else $error("phase start while blocked");
a_blocked_cause: assert property (phase_blocked |-> $past(phase_block))
    else $error("phase blocked without block input");

// Main scenarios reached
c_trip: cover property (zone_trip != 4'h0);
c_blocked: cover property (zone_blocked != 4'h0);
c_start: cover property (phase_start);
c_fault: cover property (sensor_fault != 4'h0);
endmodule

bind arc_fault_zone_trip arc_trip_checker arc_trip_checker_i
(
    .sys_clk(sys_clk), .nrst(nrst), .light_in(light_in), .pressure_in(pressure_in),
    .detected_sensors(detected_sensors), .configured_sensors(configured_sensors),
    .connected_units(connected_units), .configured_units(configured_units),
    .zone_enable(zone_enable), .zone_light_map(zone_light_map),
    .zone_phase_enable(zone_phase_enable), .zone_residual_enable(zone_residual_enable),
    .zone_block(zone_block), .phase_block(phase_block), .light_detected(light_detected),
    .zone_trip(zone_trip), .zone_blocked(zone_blocked), .sensor_fault(sensor_fault),
    .io_unit_fault(io_unit_fault), .phase_start(phase_start), .phase_blocked(phase_blocked)
);

// ---- verification/current_source.sv ----
/* Model of the current measurement channels: one sample set every four
   cycles. Assumes the bench sets the phase and residual magnitudes. */
`timescale 1ns/1ns
module current_source
(
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic [15:0] phase_level,
    input wire logic [15:0] residual_level,
    output logic [15:0] phase_a_samples,
    output logic [15:0] phase_b_samples,
    output logic [15:0] phase_c_samples,
    output logic [15:0] residual_samples_one,
    output logic [15:0] residual_samples_two,
    output logic sample_valid
);
logic [1:0] tick;

// Sample strobe, one cycle in four
always_ff @(posedge sys_clk or negedge nrst)
begin
    if (!nrst)
    begin
        tick <= 2'h0;
        sample_valid <= 1'b0;
    end
    else
    begin
        tick <= tick + 2'h1;
        sample_valid <= tick == 2'h3;
    end
end

// Between strobes the streams carry inverted junk, so unqualified counting shows
assign phase_a_samples = sample_valid ? phase_level : ~phase_level;
assign phase_b_samples = phase_a_samples;
assign phase_c_samples = phase_a_samples;
assign residual_samples_one = sample_valid ? residual_level : ~residual_level;
assign residual_samples_two = residual_samples_one;
endmodule

// ---- verification/test_arc_fault_zone_trip.sv ----
/* Testbench for the arc fault zone trip block: task driven sequences.
   Assumes the bound checker and the current source model. */
`timescale 1ns/1ns
module test_arc_fault_zone_trip;
// ********
// Signals
// ********
logic sys_clk;
logic nrst;
logic [3:0] light_in, pressure_in, connected_units, configured_units;
logic [3:0] zone_enable, zone_phase_enable, zone_residual_enable;
logic [7:0] detected_sensors, configured_sensors, required_samples;
logic [15:0] zone_light_map, phase_pickup, residual_pickup, phase_level, residual_level;
logic [15:0] pa, pb, pc, r1, r2;
logic arc_binary_input, test_pulse_filter_enable, sample_valid;
logic phase_block, residual_block, zone_block;
logic [1:0] fast_one_select, fast_two_select;
arc_fault_pkg::cur_sel_t current_mode;
arc_fault_pkg::res_sel_t residual_select;
logic [3:0] light_detected, zone_trip, zone_blocked, sensor_fault;
logic arc_input_status, phase_start, residual_start, phase_blocked, residual_blocked;
logic io_unit_fault, fast_output_one, fast_output_two;
int bad_count;
int total_checks;

// Short window and pulse limit keep the run brief
arc_fault_zone_trip #(.BASE_CYCLES(50), .PULSE_CYCLES(4)) arc_fault_zone_trip_i
(
    .sys_clk(sys_clk), .nrst(nrst), .light_in(light_in), .pressure_in(pressure_in),
    .detected_sensors(detected_sensors), .configured_sensors(configured_sensors),
    .connected_units(connected_units), .configured_units(configured_units),
    .arc_binary_input(arc_binary_input), .test_pulse_filter_enable(test_pulse_filter_enable),
    .phase_a_samples(pa), .phase_b_samples(pb), .phase_c_samples(pc),
    .residual_samples_one(r1), .residual_samples_two(r2), .sample_valid(sample_valid),
    .phase_pickup(phase_pickup), .residual_pickup(residual_pickup),
    .required_samples(required_samples), .current_mode(current_mode),
    .residual_select(residual_select), .phase_block(phase_block),
    .residual_block(residual_block), .zone_block(zone_block), .zone_enable(zone_enable),
    .zone_light_map(zone_light_map), .zone_phase_enable(zone_phase_enable),
    .zone_residual_enable(zone_residual_enable), .fast_one_select(fast_one_select),
    .fast_two_select(fast_two_select), .light_detected(light_detected),
    .arc_input_status(arc_input_status), .phase_start(phase_start),
    .residual_start(residual_start), .phase_blocked(phase_blocked),
    .residual_blocked(residual_blocked), .zone_trip(zone_trip), .zone_blocked(zone_blocked),
    .sensor_fault(sensor_fault), .io_unit_fault(io_unit_fault),
    .fast_output_one(fast_output_one), .fast_output_two(fast_output_two)
);

current_source current_source_i
(
    .sys_clk(sys_clk), .nrst(nrst), .phase_level(phase_level),
    .residual_level(residual_level), .phase_a_samples(pa), .phase_b_samples(pb),
    .phase_c_samples(pc), .residual_samples_one(r1), .residual_samples_two(r2),
    .sample_valid(sample_valid)
);

// ********
// Tasks
// ********
task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
endtask

task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp)
    begin
        bad_count++;
        $display("ERROR %s expected %h seen %h", what, exp, got);
    end
endtask

// Zone side write, launched on a rising edge
task automatic drive_zone(input logic [3:0] l, input logic [3:0] p,
    input logic [3:0] en, input logic blk);
    @(posedge sys_clk);
    light_in <= l;
    pressure_in <= p;
    zone_enable <= en;
    zone_block <= blk;
endtask

task automatic complete_run;
    if (bad_count == 0 && total_checks > 0)
        $display("Regression OK");
    else
        $display("Regression broken");
    $finish;
endtask

// Clock, 8 ns period
initial
begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
end

// Watchdog well beyond the expected run of about 700 cycles
initial
begin
    #80000;
    bad_count++;
    complete_run();
end

// ********
// Sequence
// ********
initial
begin
    {nrst, light_in, pressure_in, zone_enable, zone_phase_enable} = '0;
    {zone_residual_enable, detected_sensors, configured_sensors} = '0;
    {connected_units, configured_units, arc_binary_input, test_pulse_filter_enable} = '0;
    {phase_block, residual_block, zone_block, fast_one_select, fast_two_select} = '0;
    {phase_level, residual_level} = '0;
    zone_light_map = 16'h8421;
    phase_pickup = 16'h0100;
    residual_pickup = 16'h0100;
    required_samples = 8'h03;
    current_mode = arc_fault_pkg::CUR_NONE;
    residual_select = arc_fault_pkg::RES_ONE;
    bad_count = 0;
    total_checks = 0;
    repeat (12) @(posedge sys_clk);
    nrst <= 1'b1;
    tick(2);
    check("zone_trip", 16'h0000, zone_trip);
    check("sensor_fault", 16'h0000, sensor_fault);
    // Each channel by light, then by pressure, trips its own zone
    for (int k = 0; k < 8; k++)
    begin
        drive_zone(k < 4 ? 4'h1 << k : 4'h0, k < 4 ? 4'h0 : 4'h1 << (k - 4), 4'hf, 1'b0);
        tick(2);
        check("light_detected", 16'h0001 << (k % 4), light_detected);
        check("zone_trip", 16'h0001 << (k % 4), zone_trip);
    end
    // Channel one shared by zones one and three; zone three then disabled
    zone_light_map <= 16'h8121;
    drive_zone(4'h1, 4'h0, 4'hf, 1'b0);
    tick(2);
    check("zone_trip", 16'h0005, zone_trip);
    drive_zone(4'h1, 4'h0, 4'hb, 1'b0);
    tick(2);
    check("zone_trip", 16'h0001, zone_trip);
    drive_zone(4'h1, 4'h0, 4'hf, 1'b1);
    tick(2);
    check("zone_blocked", 16'h0005, zone_blocked);
    check("zone_trip", 16'h0000, zone_trip);
    // Sensor and unit counts against settings
    detected_sensors <= 8'he4;
    connected_units <= 4'h3;
    configured_units <= 4'h2;
    tick(2);
    check("sensor_fault", 16'h000e, sensor_fault);
    check("io_unit_fault", 16'h0001, io_unit_fault);
    configured_sensors <= 8'he4;
    configured_units <= 4'h3;
    tick(2);
    check("sensor_fault", 16'h0000, sensor_fault);
    check("io_unit_fault", 16'h0000, io_unit_fault);
    // A short wiring pulse is ignored, a long level is an arc
    test_pulse_filter_enable <= 1'b1;
    arc_binary_input <= 1'b1;
    tick(3);
    arc_binary_input <= 1'b0;
    for (int k = 0; k < 8; k++)
    begin
        tick(1);
        check("arc_input_status", 16'h0000, arc_input_status);
    end
    arc_binary_input <= 1'b1;
    tick(10);
    check("arc_input_status", 16'h0001, arc_input_status);
    // Zone one with phase current; current equal to pick-up does not count
    zone_light_map <= 16'h8421;
    zone_phase_enable <= 4'h1;
    current_mode <= arc_fault_pkg::CUR_PHASE;
    phase_level <= 16'h0100;
    drive_zone(4'h1, 4'h0, 4'h1, 1'b0);
    tick(120);
    check("zone_trip", 16'h0000, zone_trip);
    required_samples <= 8'hff;
    phase_level <= 16'h0101;
    tick(120);
    check("phase_start", 16'h0000, phase_start);
    required_samples <= 8'h03;
    for (int i = 0; i < 120 && phase_start !== 1'b1; i++)
        tick(1);
    tick(1);
    check("phase_start", 16'h0001, phase_start);
    check("zone_trip", 16'h0001, zone_trip);
    fast_one_select <= 2'h3;
    fast_two_select <= 2'h1;
    tick(3);
    check("fast_output_one", 16'h0001, fast_output_one);
    check("fast_output_two", 16'h0001, fast_output_two);
    phase_block <= 1'b1;
    tick(3);
    check("phase_blocked", 16'h0001, phase_blocked);
    check("phase_start", 16'h0000, phase_start);
    phase_block <= 1'b0;
    // Phase only, residual only, then both
    residual_level <= 16'h0200;
    fast_two_select <= 2'h2;
    for (int m = 1; m < 4; m++)
    begin
        current_mode <= arc_fault_pkg::cur_sel_t'(m[1:0]);
        tick(110);
        check("phase_start", 16'(m[0]), phase_start);
        check("residual_start", 16'(m[1]), residual_start);
        check("fast_output_two", 16'(m[1]), fast_output_two);
    end
    // Residual blocking input turns the residual start into blocked
    residual_block <= 1'b1;
    tick(3);
    check("residual_blocked", 16'h0001, residual_blocked);
    check("residual_start", 16'h0000, residual_start);
    complete_run();
end
endmodule
